// ### verilog/eac_pkg.sv
// Purpose: Shared constants and types of the nonvolatile access controller
// Assumes: Core I/O addresses are six bits wide
// Notes: Programming times are counted in calibrated clock ticks
package eac_pkg;

  // I/O addresses
  localparam logic [5:0] ADDR_CTRL = 6'h1f;
  localparam logic [5:0] ADDR_DATA = 6'h20;
  localparam logic [5:0] ADDR_ADRL = 6'h21;
  localparam logic [5:0] ADDR_ADRH = 6'h22;

  // Control register fields
  localparam int CTL_RD_BIT = 0;
  localparam int CTL_PRG_BIT = 1;
  localparam int CTL_ARM_BIT = 2;
  localparam int CTL_IRQ_BIT = 3;
  localparam int CTL_MODE_LO = 4;
  localparam int CTL_MODE_HI = 5;
  localparam int ADDR_HI_BIT = 8;

  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 9'h000;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  typedef enum logic [1:0] {
    MODE_ATOMIC = 2'h0,
    MODE_ERASE = 2'h1,
    MODE_WRITE = 2'h2,
    MODE_RSVD = 2'h3
  } eac_mode_e;

  typedef enum logic {
    TMR_IDLE = 1'b0,
    TMR_RUN = 1'b1
  } eac_tmr_e;

  // Core cycle counts
  localparam int STALL_W = 3;
  localparam logic [STALL_W-1:0] ARM_CYCLES = 3'h4;
  localparam logic [STALL_W-1:0] PROG_STALL = 3'h2;
  localparam logic [STALL_W-1:0] READ_STALL = 3'h4;
  localparam logic [STALL_W-1:0] STALL_STEP = 3'h1;
  localparam logic [STALL_W-1:0] STALL_NONE = 3'h0;

  // Programming times
  localparam int CAL_CLK_KHZ = 8000;
  localparam int T_ATOMIC_US = 3400;
  localparam int T_SPLIT_US = 1800;
  localparam int KHZ_US_DIV = 1000;
  localparam int ATOMIC_TICKS_DEF = T_ATOMIC_US * CAL_CLK_KHZ / KHZ_US_DIV;
  localparam int SPLIT_TICKS_DEF = T_SPLIT_US * CAL_CLK_KHZ / KHZ_US_DIV;

  localparam int CNT_W = 16;
  typedef logic [CNT_W-1:0] eac_cnt_t;
  localparam eac_cnt_t CNT_ZERO = 16'h0000;
  localparam eac_cnt_t CNT_ONE = 16'h0001;

  function automatic logic mode_ok(input eac_mode_e m);
    mode_ok = (m != MODE_RSVD);
  endfunction

  function automatic logic mode_erases(input eac_mode_e m);
    mode_erases = (m == MODE_ATOMIC) || (m == MODE_ERASE);
  endfunction

  function automatic logic mode_writes(input eac_mode_e m);
    mode_writes = (m == MODE_ATOMIC) || (m == MODE_WRITE);
  endfunction

endpackage

// ### verilog/eac_ctl_if.sv
// Purpose: Links the register logic with the arm window and the timer
// Assumes: All members are on mclk
// Notes: None
`timescale 1ns/1ps
interface eac_ctl_if;
  import eac_pkg::*;
  logic arm_set;
  logic arm_on;
  logic prog_start;
  eac_mode_e prog_mode;
  logic prog_busy;
  modport arm_mp(input arm_set, output arm_on);
  modport tmr_mp(input prog_start, input prog_mode, output prog_busy);
  modport ctl_mp(output arm_set, output prog_start, output prog_mode,
                 input arm_on, input prog_busy);
endinterface

// ### verilog/eac_arm_window.sv
// Purpose: Master arm window that closes itself after a fixed count
// Assumes: arm_set is a one-cycle pulse from the register logic
// Notes: A new arm write restarts the window
`timescale 1ns/1ps
module eac_arm_window
  import eac_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  eac_ctl_if.arm_mp aif
);

  logic [STALL_W-1:0] arm_cnt_ff;

  always_ff @(posedge mclk) begin
    if (rst) begin
      arm_cnt_ff <= STALL_NONE;
    end else if (aif.arm_set) begin
      arm_cnt_ff <= ARM_CYCLES;
    end else if (arm_cnt_ff != STALL_NONE) begin
      arm_cnt_ff <= arm_cnt_ff - STALL_STEP;
    end
  end

  assign aif.arm_on = (arm_cnt_ff != STALL_NONE);

  arm_hold_a: assert property (
    @(posedge mclk) disable iff (rst)
    aif.arm_set |=> aif.arm_on[*4]
  ) else $error("arm window shorter than four cycles");

  arm_clear_a: assert property (
    @(posedge mclk) disable iff (rst)
    (aif.arm_set ##1 (!aif.arm_set)[*4]) |=> !aif.arm_on
  ) else $error("arm bit not cleared after four cycles");

endmodule

// ### verilog/eac_prog_timer.sv
// Purpose: Self-timed programming duration from the calibrated clock
// Assumes: cal_clk is well below half the mclk rate
// Notes: Only the power-on reset stops a running cycle
`timescale 1ns/1ps
module eac_prog_timer
  import eac_pkg::*;
#(
  parameter int ATOMIC_TICKS = ATOMIC_TICKS_DEF,
  parameter int SPLIT_TICKS = SPLIT_TICKS_DEF
)
(
  input wire logic mclk,
  input wire logic por_rst,
  input wire logic cal_clk,
  eac_ctl_if.tmr_mp tif
);

  logic cal_s1_ff;
  logic cal_s2_ff;
  logic cal_s3_ff;
  logic tick;
  eac_tmr_e state_ff;
  eac_cnt_t cnt_ff;

  function automatic eac_cnt_t ticks_of(input eac_mode_e m);
    ticks_of = (m == MODE_ATOMIC) ? eac_cnt_t'(ATOMIC_TICKS)
                                  : eac_cnt_t'(SPLIT_TICKS);
  endfunction

  always_ff @(posedge mclk) begin
    if (por_rst) begin
      cal_s1_ff <= 1'b0;
      cal_s2_ff <= 1'b0;
      cal_s3_ff <= 1'b0;
    end else begin
      cal_s1_ff <= cal_clk;
      cal_s2_ff <= cal_s1_ff;
      cal_s3_ff <= cal_s2_ff;
    end
  end

  assign tick = cal_s2_ff & ~cal_s3_ff;

  always_ff @(posedge mclk) begin
    if (por_rst) begin
      state_ff <= TMR_IDLE;
      cnt_ff <= CNT_ZERO;
    end else begin
      unique case (state_ff)
        TMR_IDLE: begin
          if (tif.prog_start) begin
            state_ff <= TMR_RUN;
            cnt_ff <= ticks_of(tif.prog_mode);
          end
        end
        TMR_RUN: begin
          if (tick) begin
            if (cnt_ff <= CNT_ONE) begin
              state_ff <= TMR_IDLE;
              cnt_ff <= CNT_ZERO;
            end else begin
              cnt_ff <= cnt_ff - CNT_ONE;
            end
          end
        end
      endcase
    end
  end

  assign tif.prog_busy = (state_ff == TMR_RUN);

  busy_start_a: assert property (
    @(posedge mclk) disable iff (por_rst)
    (tif.prog_start && !tif.prog_busy) |=> tif.prog_busy ##1 tif.prog_busy
  ) else $error("busy flag did not rise on start");

  busy_tick_a: assert property (
    @(posedge mclk) disable iff (por_rst)
    $fell(tif.prog_busy) |-> $past(tick) && ($past(cnt_ff) <= CNT_ONE)
  ) else $error("busy flag fell before the count ran out");

endmodule

// ### verilog/eac_nvm_ctrl.sv
// Purpose: Core-side register logic of the byte EEPROM access controller
// Assumes: Array returns read data one cycle after arr_rd_ff
// Notes: por_rst clears all; rst spares a running programming cycle
// Operation
// - Mode field picks atomic, erase or write
// - Mode writes ignored while programming runs
// - Reset clears mode unless programming runs
// - Level ready interrupt when enabled and idle
// - Program strobe works only inside arm window
// - Arm bit self-clears after four cycles
// - Busy bit holds for whole programming time
// - Program start halts core two cycles
// - Read strobe loads data register three cycles later
// - Read strobe halts core four cycles
// - Busy refuses reads and address changes
// - Nine-bit linear address, high bits zero
// - Data register feeds writes, takes reads
// - Reset lets running programming finish
// - Control bits seven and six read zero
`timescale 1ns/1ps
module eac_nvm_ctrl
  import eac_pkg::*;
#(
  parameter int ATOMIC_TICKS = ATOMIC_TICKS_DEF,
  parameter int SPLIT_TICKS = SPLIT_TICKS_DEF
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic por_rst,
  input wire logic [5:0] io_addr,
  input wire logic io_we,
  input wire logic io_re,
  input wire logic [DATA_W-1:0] io_wdata,
  output logic [DATA_W-1:0] io_rdata_ff,
  input wire logic core_gie,
  input wire logic cal_clk,
  output logic cpu_halt_ff,
  output logic ready_irq_ff,
  output logic [ADDR_W-1:0] arr_addr_ff,
  output logic [DATA_W-1:0] arr_wdata_ff,
  output logic arr_erase_ff,
  output logic arr_write_ff,
  output logic arr_rd_ff,
  input wire logic [DATA_W-1:0] arr_rdata
);

  eac_ctl_if cif();

  eac_mode_e mode_ff;
  eac_mode_e arr_mode_ff;
  logic irq_en_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] data_ff;
  logic rd_cap_ff;
  logic [STALL_W-1:0] stall_ff;
  logic busy;
  logic wr_ctl;
  logic wr_data;
  logic wr_adrl;
  logic wr_adrh;
  logic prog_req;
  logic rd_req;
  eac_mode_e wr_mode;

  eac_arm_window u_arm (
    .mclk(mclk),
    .rst(rst | por_rst),
    .aif(cif.arm_mp)
  );

  eac_prog_timer #(
    .ATOMIC_TICKS(ATOMIC_TICKS),
    .SPLIT_TICKS(SPLIT_TICKS)
  ) u_tmr (
    .mclk(mclk),
    .por_rst(por_rst),
    .cal_clk(cal_clk),
    .tif(cif.tmr_mp)
  );

  // Write decode
  assign busy = cif.prog_busy;
  assign wr_ctl = io_we && (io_addr == ADDR_CTRL);
  assign wr_data = io_we && (io_addr == ADDR_DATA);
  assign wr_adrl = io_we && (io_addr == ADDR_ADRL);
  assign wr_adrh = io_we && (io_addr == ADDR_ADRH);
  assign wr_mode = eac_mode_e'(io_wdata[CTL_MODE_HI:CTL_MODE_LO]);

  // Program start needs the open arm window and a legal mode
  assign prog_req = wr_ctl && io_wdata[CTL_PRG_BIT] && cif.arm_on
                    && !busy && mode_ok(wr_mode) && !rst;
  // Program wins if both strobes come in one byte
  assign rd_req = wr_ctl && io_wdata[CTL_RD_BIT] && !busy
                  && !prog_req && !rst;

  assign cif.arm_set = wr_ctl && io_wdata[CTL_ARM_BIT] && !rst;
  assign cif.prog_start = prog_req;
  assign cif.prog_mode = wr_mode;

  // Mode field
  always_ff @(posedge mclk) begin
    if (por_rst) begin
      mode_ff <= MODE_ATOMIC;
    end else if (busy) begin
      mode_ff <= mode_ff;
    end else if (rst) begin
      mode_ff <= MODE_ATOMIC;
    end else if (wr_ctl) begin
      mode_ff <= wr_mode;
    end
  end

  // Interrupt enable
  always_ff @(posedge mclk) begin
    if (rst || por_rst) begin
      irq_en_ff <= 1'b0;
    end else if (wr_ctl) begin
      irq_en_ff <= io_wdata[CTL_IRQ_BIT];
    end
  end

  // Address, frozen during programming
  always_ff @(posedge mclk) begin
    if (por_rst) begin
      addr_ff <= ADDR_RST;
    end else if (!busy && !rst) begin
      if (wr_adrl) begin
        addr_ff[DATA_W-1:0] <= io_wdata;
      end
      if (wr_adrh) begin
        addr_ff[ADDR_HI_BIT] <= io_wdata[0];
      end
    end
  end

  // Data register
  always_ff @(posedge mclk) begin
    if (rst || por_rst) begin
      data_ff <= DATA_RST;
    end else if (rd_cap_ff) begin
      data_ff <= arr_rdata;
    end else if (wr_data) begin
      data_ff <= io_wdata;
    end
  end

  // Array port, kept alive across rst for a running cycle
  always_ff @(posedge mclk) begin
    if (por_rst) begin
      arr_addr_ff <= ADDR_RST;
      arr_wdata_ff <= DATA_RST;
      arr_mode_ff <= MODE_ATOMIC;
    end else if (prog_req) begin
      arr_addr_ff <= addr_ff;
      arr_wdata_ff <= data_ff;
      arr_mode_ff <= wr_mode;
    end else if (rd_req) begin
      arr_addr_ff <= addr_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (por_rst) begin
      arr_erase_ff <= 1'b0;
      arr_write_ff <= 1'b0;
    end else begin
      arr_erase_ff <= busy && mode_erases(arr_mode_ff);
      arr_write_ff <= busy && mode_writes(arr_mode_ff);
    end
  end

  // Read strobe and capture
  always_ff @(posedge mclk) begin
    if (rst || por_rst) begin
      arr_rd_ff <= 1'b0;
      rd_cap_ff <= 1'b0;
    end else begin
      arr_rd_ff <= rd_req;
      rd_cap_ff <= arr_rd_ff;
    end
  end

  // Core halt
  always_ff @(posedge mclk) begin
    if (rst || por_rst) begin
      stall_ff <= STALL_NONE;
      cpu_halt_ff <= 1'b0;
    end else if (prog_req) begin
      stall_ff <= PROG_STALL - STALL_STEP;
      cpu_halt_ff <= 1'b1;
    end else if (rd_req) begin
      stall_ff <= READ_STALL - STALL_STEP;
      cpu_halt_ff <= 1'b1;
    end else if (stall_ff != STALL_NONE) begin
      stall_ff <= stall_ff - STALL_STEP;
      cpu_halt_ff <= 1'b1;
    end else begin
      cpu_halt_ff <= 1'b0;
    end
  end

  // Ready interrupt
  always_ff @(posedge mclk) begin
    if (rst || por_rst) begin
      ready_irq_ff <= 1'b0;
    end else begin
      ready_irq_ff <= irq_en_ff && core_gie && !busy;
    end
  end

  // Read data
  always_ff @(posedge mclk) begin
    if (rst || por_rst) begin
      io_rdata_ff <= READ_ZERO;
    end else if (io_re) begin
      io_rdata_ff <= READ_ZERO;
      unique case (io_addr)
        ADDR_CTRL: begin
          io_rdata_ff[CTL_MODE_HI:CTL_MODE_LO] <= mode_ff;
          io_rdata_ff[CTL_IRQ_BIT] <= irq_en_ff;
          io_rdata_ff[CTL_ARM_BIT] <= cif.arm_on;
          io_rdata_ff[CTL_PRG_BIT] <= busy;
        end
        ADDR_DATA: begin
          io_rdata_ff <= data_ff;
        end
        ADDR_ADRL: begin
          io_rdata_ff <= addr_ff[DATA_W-1:0];
        end
        ADDR_ADRH: begin
          io_rdata_ff[0] <= addr_ff[ADDR_HI_BIT];
        end
        default: begin
          io_rdata_ff <= READ_ZERO;
        end
      endcase
    end else begin
      io_rdata_ff <= READ_ZERO;
    end
  end

  mode_hold_a: assert property (
    @(posedge mclk) disable iff (por_rst)
    busy |=> (mode_ff == $past(mode_ff))
  ) else $error("mode changed while programming");

  mode_reset_a: assert property (
    @(posedge mclk) disable iff (por_rst)
    (rst && !busy) |=> (mode_ff == MODE_ATOMIC)
  ) else $error("mode not cleared by reset");

  irq_level_a: assert property (
    @(posedge mclk) disable iff (rst || por_rst)
    (irq_en_ff && core_gie && !busy)[*2] |-> ready_irq_ff
  ) else $error("ready interrupt missing");

  prog_arm_a: assert property (
    @(posedge mclk) disable iff (por_rst)
    $rose(busy) |-> $past(wr_ctl && io_wdata[CTL_PRG_BIT] && cif.arm_on)
  ) else $error("programming started without arm");

  prog_stall_a: assert property (
    @(posedge mclk) disable iff (rst || por_rst)
    prog_req |=> cpu_halt_ff[*2] ##1 !cpu_halt_ff
  ) else $error("program halt not two cycles");

  read_stall_a: assert property (
    @(posedge mclk) disable iff (rst || por_rst)
    rd_req |=> cpu_halt_ff[*4] ##1 !cpu_halt_ff
  ) else $error("read halt not four cycles");

  read_data_a: assert property (
    @(posedge mclk) disable iff (rst || por_rst)
    rd_req |-> ##3 (data_ff == $past(arr_rdata))
  ) else $error("read byte not captured");

  addr_lock_a: assert property (
    @(posedge mclk) disable iff (por_rst)
    busy |=> (addr_ff == $past(addr_ff)) && !arr_rd_ff
  ) else $error("address or read not blocked");

  ctl_rsvd_a: assert property (
    @(posedge mclk) disable iff (rst || por_rst)
    (io_re && io_addr == ADDR_CTRL) |=> (io_rdata_ff[7:6] == 2'b00)
  ) else $error("reserved control bits not zero");

  irq_busy_a: assert property (
    @(posedge mclk) disable iff (por_rst)
    busy |=> !ready_irq_ff
  ) else $error("ready interrupt raised while busy");

  adrh_zero_a: assert property (
    @(posedge mclk) disable iff (rst || por_rst)
    (io_re && io_addr == ADDR_ADRH) |=> (io_rdata_ff[DATA_W-1:1] == '0)
  ) else $error("unused address bits not zero");

  arr_load_a: assert property (
    @(posedge mclk) disable iff (por_rst)
    prog_req |=> (arr_addr_ff == $past(addr_ff))
             && (arr_wdata_ff == $past(data_ff))
  ) else $error("array port not loaded at start");

endmodule

// ### test/eac_arr_model.sv
// Purpose: Byte array behind the access controller
// Assumes: Erase and write are levels for the whole programming time
// Notes: Unerased bytes take an AND on write-only; idle read data toggles
`timescale 1ns/1ps
module eac_arr_model
  import eac_pkg::*;
(
  input wire logic mclk,
  input wire logic [ADDR_W-1:0] arr_addr,
  input wire logic [DATA_W-1:0] arr_wdata,
  input wire logic arr_erase,
  input wire logic arr_write,
  input wire logic arr_rd,
  output logic [DATA_W-1:0] arr_rdata
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic er_q = 1'b0;
  logic wr_q = 1'b0;
  logic [ADDR_W-1:0] wa_q;
  logic [DATA_W-1:0] wd_q;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    arr_rdata = 8'h00;
  end
  always @(posedge mclk) begin
    if (arr_erase || arr_write) begin
      er_q <= er_q | arr_erase;
      wr_q <= wr_q | arr_write;
      wa_q <= arr_addr;
      wd_q <= arr_wdata;
    end else if (er_q || wr_q) begin
      mem[wa_q] <= (er_q ? 8'hff : mem[wa_q]) & (wr_q ? wd_q : 8'hff);
      er_q <= 1'b0;
      wr_q <= 1'b0;
    end
    if (arr_rd) begin
      arr_rdata <= mem[arr_addr];
    end else begin
      arr_rdata <= ~arr_rdata;
    end
  end
endmodule

// ### test/testbench.sv
// Purpose: Register-level tests of the byte array access controller
// Assumes: Short programming counts, cal_clk near 8 MHz
// Notes: Bus tasks start and end on the falling edge
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("[ERR] %0t got %h exp %h", $time, (g), (e)); \
  end end
module testbench;
  import eac_pkg::*;
  localparam int ATK = 12;
  localparam int SPK = 6;
  localparam int MID = (ATK + SPK) * 5 / 2;
  logic mclk = 1'b0;
  logic cal_clk = 1'b0;
  logic rst = 1'b1;
  logic por_rst = 1'b1;
  logic [5:0] io_addr = 6'h00;
  logic io_we = 1'b0;
  logic io_re = 1'b0;
  logic [DATA_W-1:0] io_wdata = 8'h00;
  logic core_gie = 1'b0;
  logic [DATA_W-1:0] io_rdata_ff, arr_wdata_ff, arr_rdata, rv;
  logic [ADDR_W-1:0] arr_addr_ff;
  logic cpu_halt_ff, ready_irq_ff, arr_erase_ff, arr_write_ff, arr_rd_ff;
  logic ie = 1'b0;
  logic [1:0] tmode [3] = '{2'h0, 2'h1, 2'h2};
  logic [7:0] tdat [3] = '{8'ha5, 8'h00, 8'h3c};
  logic [7:0] texp [3] = '{8'ha5, 8'hff, 8'h3c};
  int num_errors = 0;
  int total_checks = 0;
  int h;
  int b;
  int hc = 0;
  int h0 = 0;

  always #12.5 mclk = ~mclk;
  always #62.4 cal_clk = ~cal_clk;

  // Halt cycles seen at each falling edge, from the strobe edge on
  always @(negedge mclk) begin
    if (cpu_halt_ff === 1'b1) hc++;
  end

  eac_nvm_ctrl #(.ATOMIC_TICKS(ATK), .SPLIT_TICKS(SPK)) i_eac_nvm_ctrl (
    .mclk(mclk), .rst(rst), .por_rst(por_rst), .io_addr(io_addr),
    .io_we(io_we), .io_re(io_re), .io_wdata(io_wdata),
    .io_rdata_ff(io_rdata_ff), .core_gie(core_gie), .cal_clk(cal_clk),
    .cpu_halt_ff(cpu_halt_ff), .ready_irq_ff(ready_irq_ff),
    .arr_addr_ff(arr_addr_ff), .arr_wdata_ff(arr_wdata_ff),
    .arr_erase_ff(arr_erase_ff), .arr_write_ff(arr_write_ff),
    .arr_rd_ff(arr_rd_ff), .arr_rdata(arr_rdata));

  eac_arr_model i_eac_arr_model (
    .mclk(mclk), .arr_addr(arr_addr_ff), .arr_wdata(arr_wdata_ff),
    .arr_erase(arr_erase_ff), .arr_write(arr_write_ff),
    .arr_rd(arr_rd_ff), .arr_rdata(arr_rdata));

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_we = 1'b1;
    @(negedge mclk);
    io_we = 1'b0;
    @(negedge mclk);
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    io_addr = a;
    io_re = 1'b1;
    @(negedge mclk);
    io_re = 1'b0;
    d = io_rdata_ff;
    @(negedge mclk);
  endtask

  task automatic setaddr(input logic [8:0] a);
    wr(ADDR_ADRL, a[7:0]);
    wr(ADDR_ADRH, {7'h00, a[8]});
  endtask

  // Arm, wait gap cycles, then strobe
  task automatic start(input logic [8:0] a, input logic [7:0] d,
                       input logic [1:0] m, input int gap);
    setaddr(a);
    wr(ADDR_DATA, d);
    wr(ADDR_CTRL, {2'b00, m, ie, 3'b100});
    repeat (gap) @(negedge mclk);
    h0 = hc;
    wr(ADDR_CTRL, {2'b00, m, ie, 3'b010});
  endtask

  // Count halt and array-busy cycles until the array goes quiet
  task automatic watch();
    b = 0;
    for (int i = 0; i < 300; i++) begin
      if ((arr_erase_ff | arr_write_ff) === 1'b1) b++;
      if (i > 8 && (arr_erase_ff | arr_write_ff) === 1'b0) break;
      @(negedge mclk);
    end
    repeat (4) @(negedge mclk);
    h = hc - h0;
  endtask

  task automatic eeread(input logic [8:0] a, output logic [7:0] d);
    do begin
      rd(ADDR_CTRL, d);
    end while (d[CTL_PRG_BIT] !== 1'b0);
    setaddr(a);
    h0 = hc;
    wr(ADDR_CTRL, 8'h01);
    watch();
    rd(ADDR_DATA, d);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end

  initial begin
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    por_rst = 1'b0;
    @(negedge mclk);
    rd(ADDR_CTRL, rv); `CHK(rv, 8'h00)
    rd(ADDR_DATA, rv); `CHK(rv, 8'h00)
    rd(ADDR_ADRH, rv); `CHK(rv, 8'h00)
    rd(6'h23, rv); `CHK(rv, 8'h00)
    wr(ADDR_CTRL, 8'h38);
    rd(ADDR_CTRL, rv); `CHK(rv, 8'h38)
    wr(ADDR_ADRH, 8'hff);
    rd(ADDR_ADRH, rv); `CHK(rv, 8'h01)
    wr(ADDR_ADRL, 8'h5a);
    rd(ADDR_ADRL, rv); `CHK(rv, 8'h5a)
    start(9'h0aa, 8'h55, 2'h3, 0);
    watch(); `CHK(h, 0)
    `CHK(b, 0)
    // Atomic, erase, then write-only on the freshly erased byte
    for (int k = 0; k < 3; k++) begin
      start(9'h1c3, tdat[k], tmode[k], 0);
      watch(); `CHK(h, 2)
      `CHK(b >= MID, k == 0)
      rd(ADDR_CTRL, rv); `CHK(rv, {2'b00, tmode[k], 4'h0})
      eeread(9'h1c3, rv); `CHK(h, 4)
      `CHK(rv, texp[k])
    end
    wr(ADDR_CTRL, 8'h04);
    rd(ADDR_CTRL, rv); `CHK(rv, 8'h04)
    rd(ADDR_CTRL, rv); `CHK(rv, 8'h04)
    rd(ADDR_CTRL, rv); `CHK(rv, 8'h00)
    start(9'h007, 8'h42, 2'h0, 3);
    watch(); `CHK(h + b, 0)
    start(9'h007, 8'h42, 2'h0, 2);
    watch(); `CHK(b > 0, 1'b1)
    eeread(9'h007, rv); `CHK(rv, 8'h42)
    ie = 1'b1;
    core_gie = 1'b1;
    start(9'h010, 8'h11, 2'h0, 0);
    repeat (2) @(negedge mclk);
    rd(ADDR_CTRL, rv); `CHK(rv, 8'h0a)
    `CHK(ready_irq_ff, 1'b0)
    wr(ADDR_CTRL, 8'h28);
    rd(ADDR_CTRL, rv); `CHK(rv, 8'h0a)
    wr(ADDR_ADRL, 8'h99);
    rd(ADDR_ADRL, rv); `CHK(rv, 8'h10)
    wr(ADDR_CTRL, 8'h09);
    rd(ADDR_DATA, rv); `CHK(rv, 8'h11)
    watch();
    rd(ADDR_CTRL, rv); `CHK(rv, 8'h08)
    `CHK(ready_irq_ff, 1'b1)
    core_gie = 1'b0;
    repeat (2) @(negedge mclk);
    `CHK(ready_irq_ff, 1'b0)
    core_gie = 1'b1;
    wr(ADDR_CTRL, 8'h00);
    @(negedge mclk);
    `CHK(ready_irq_ff, 1'b0)
    ie = 1'b0;
    start(9'h020, 8'h00, 2'h1, 0);
    @(negedge mclk);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    rd(ADDR_CTRL, rv); `CHK(rv, 8'h12)
    watch();
    rd(ADDR_CTRL, rv); `CHK(rv, 8'h10)
    eeread(9'h020, rv); `CHK(rv, 8'hff)
    wr(ADDR_CTRL, 8'h20);
    wr(ADDR_DATA, 8'h77);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    rd(ADDR_CTRL, rv); `CHK(rv, 8'h00)
    rd(ADDR_DATA, rv); `CHK(rv, 8'h00)
    results();
  end
endmodule
